// *** rtl/plr_pkg.sv ***
package plr_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] UV_LIMIT_OFF    = 8'h34;
  localparam logic [7:0] LINE_IMP_OFF    = 8'h35;
  localparam logic [7:0] DROOP_CTRL_OFF  = 8'h36;
  localparam logic [7:0] STATUS_OFF      = 8'h02;

  // ==========================================================
  // Field positions
  localparam int EOC_SHDN_BIT   = 7;
  localparam int UV_SET_MSB     = 6;
  localparam int DROOP_EN_BIT   = 3;
  localparam int DROOP_SEL_MSB  = 2;
  localparam int LINE_FLAG_BIT  = 2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] UV_LIMIT_RST   = 8'h00;
  localparam logic [7:0] LINE_IMP_RST   = 8'h00;
  localparam logic [7:0] DROOP_CTRL_RST = 8'h00;

  // ==========================================================
  // Threshold scaling: setting/128 x 1550 mV
  localparam logic [10:0] UV_FULL_MV    = 11'h60e;
  localparam int          UV_STEPS_LOG2 = 7;
  localparam logic [6:0]  UV_NOMINAL    = 7'h42;

  // ==========================================================
  // Droop impedance per code, units of 0.05 mOhm
  localparam logic [10:0] IMP_CODE0 = 11'h406;
  localparam logic [10:0] IMP_CODE1 = 11'h208;
  localparam logic [10:0] IMP_CODE2 = 11'h0fa;
  localparam logic [10:0] IMP_CODE3 = 11'h07d;
  localparam logic [10:0] IMP_CODE4 = 11'h03c;
  localparam logic [10:0] IMP_CODE5 = 11'h01e;
  localparam logic [10:0] IMP_CODE6 = 11'h00e;
  localparam logic [10:0] IMP_CODE7 = 11'h000;
  localparam int          LOAD_FS_LOG2 = 12;

  // Shutdown sequencing states
  typedef enum logic [1:0] {SHDN_RUN, SHDN_PEND, SHDN_OFF} plr_shdn_type;
endpackage : plr_pkg

// *** rtl/plr_droop.sv ***
`timescale 1ns/1ps
`default_nettype none
module plr_droop (
  input  wire logic        sys_clk_i,   // System clock
  input  wire logic        rst_b_i,     // Sync reset, active low
  input  wire logic        enable_i,    // Load line enable
  input  wire logic [2:0]  sel_i,       // Impedance select
  input  wire logic [11:0] load_i,      // Load current, 4095 = full load
  output logic      [10:0] droop_o      // Droop, full-load-amps x 0.05 mOhm
);
  logic [10:0] imp;
  logic [22:0] prod;

  // ==========================================================
  // Impedance lookup
  always_comb begin
    case (sel_i)
      3'h0:    imp = plr_pkg::IMP_CODE0;
      3'h1:    imp = plr_pkg::IMP_CODE1;
      3'h2:    imp = plr_pkg::IMP_CODE2;
      3'h3:    imp = plr_pkg::IMP_CODE3;
      3'h4:    imp = plr_pkg::IMP_CODE4;
      3'h5:    imp = plr_pkg::IMP_CODE5;
      3'h6:    imp = plr_pkg::IMP_CODE6;
      default: imp = plr_pkg::IMP_CODE7;
    endcase
  end

  // Linear in load current
  assign prod = load_i * imp;

  // Registered droop, zero when disabled
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      droop_o <= 11'h000;
    end else if (enable_i) begin
      droop_o <= prod[22:plr_pkg::LOAD_FS_LOG2];
    end else begin
      droop_o <= 11'h000;
    end
  end
endmodule : plr_droop
`default_nettype wire

// *** rtl/plr_top.sv ***
// What this block does
// - Aux PWM stops at once on fault
// - Bit 7 picks cycle-end or immediate main PWM stop while aux regulates
// - Threshold equals setting/128 times 1.55 V
// - Setting 0 is 0%, 66 is 100%
// - Flag when measured impedance exceeds limit
// - Impedance flag is status 0x02 bit 2
// - Droop applied only when enable set
// - Three-bit code selects droop impedance
`timescale 1ns/1ps
`default_nettype none
module plr_top (
  input  wire logic        sys_clk_i,      // System clock
  input  wire logic        rst_b_i,        // Sync reset, active low
  input  wire logic [7:0]  reg_addr_i,     // Register address
  input  wire logic [7:0]  reg_wdata_i,    // Write data
  input  wire logic        reg_wr_i,       // Write strobe
  input  wire logic        reg_rd_i,       // Read strobe
  output logic      [7:0]  reg_rdata_o,    // Read data
  input  wire logic [10:0] local_sense_voltage_i, // Sense voltage, mV
  input  wire logic [7:0]  line_imp_i,     // Measured line impedance
  input  wire logic [11:0] load_i,         // Load current, 4095 = full
  input  wire logic        fault_shdn_i,   // Any fault demands shutdown
  input  wire logic        aux_regulating_i, // Aux PWM is regulating output
  input  wire logic        cycle_end_i,    // Switching cycle end pulse
  output logic      [10:0] uv_threshold_o, // Undervoltage threshold, mV
  output logic             undervoltage_protection_o, // Sense below threshold
  output logic             line_imp_flag_o, // Line impedance flag
  output logic             aux_pwm_output_off_o, // Aux PWM disable
  output logic             main_pwm_off_o, // Other PWM outputs disable
  output logic      [10:0] droop_o         // Droop for voltage reference
);
  logic [7:0]  uv_limit_r;
  logic [7:0]  line_imp_r;
  logic [7:0]  droop_ctrl_r;
  logic [7:0]  rdata_nxt;
  logic [17:0] uv_prod;
  logic [10:0] uv_thr_nxt;
  plr_pkg::plr_shdn_type shdn_r;

  // ==========================================================
  // Register writes
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      uv_limit_r   <= plr_pkg::UV_LIMIT_RST;
      line_imp_r   <= plr_pkg::LINE_IMP_RST;
      droop_ctrl_r <= plr_pkg::DROOP_CTRL_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        plr_pkg::UV_LIMIT_OFF:   uv_limit_r   <= reg_wdata_i;
        plr_pkg::LINE_IMP_OFF:   line_imp_r   <= reg_wdata_i;
        plr_pkg::DROOP_CTRL_OFF: droop_ctrl_r <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Read mux, unmapped reads zero
  always_comb begin
    case (reg_addr_i)
      plr_pkg::UV_LIMIT_OFF:   rdata_nxt = uv_limit_r;
      plr_pkg::LINE_IMP_OFF:   rdata_nxt = line_imp_r;
      plr_pkg::DROOP_CTRL_OFF: rdata_nxt = droop_ctrl_r;
      plr_pkg::STATUS_OFF: begin
        rdata_nxt = 8'h00;
        rdata_nxt[plr_pkg::LINE_FLAG_BIT] = line_imp_flag_o;
      end
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  // ==========================================================
  // Undervoltage threshold: setting x 1550 / 128
  assign uv_prod    = uv_limit_r[plr_pkg::UV_SET_MSB:0] * plr_pkg::UV_FULL_MV;
  assign uv_thr_nxt = uv_prod[17:plr_pkg::UV_STEPS_LOG2];

  // Threshold and undervoltage compare
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      uv_threshold_o            <= 11'h000;
      undervoltage_protection_o <= 1'b0;
    end else begin
      uv_threshold_o            <= uv_thr_nxt;
      undervoltage_protection_o <= (local_sense_voltage_i < uv_thr_nxt);
    end
  end

  // ==========================================================
  // Line impedance compare
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      line_imp_flag_o <= 1'b0;
    end else begin
      line_imp_flag_o <= (line_imp_i > line_imp_r);
    end
  end

  // ==========================================================
  // Shutdown sequencing of PWM outputs
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      shdn_r <= plr_pkg::SHDN_RUN;
    end else begin
      case (shdn_r)
        plr_pkg::SHDN_RUN: begin
          if (fault_shdn_i) begin
            if (aux_regulating_i && uv_limit_r[plr_pkg::EOC_SHDN_BIT] && !cycle_end_i) begin
              shdn_r <= plr_pkg::SHDN_PEND;
            end else begin
              shdn_r <= plr_pkg::SHDN_OFF;
            end
          end
        end
        plr_pkg::SHDN_PEND: begin
          if (!fault_shdn_i) begin
            shdn_r <= plr_pkg::SHDN_RUN;
          end else if (cycle_end_i) begin
            shdn_r <= plr_pkg::SHDN_OFF;
          end
        end
        plr_pkg::SHDN_OFF: begin
          if (!fault_shdn_i) begin
            shdn_r <= plr_pkg::SHDN_RUN;
          end
        end
        default: shdn_r <= plr_pkg::SHDN_RUN;
      endcase
    end
  end

  // PWM disable outputs
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      aux_pwm_output_off_o <= 1'b0;
      main_pwm_off_o       <= 1'b0;
    end else begin
      aux_pwm_output_off_o <= fault_shdn_i;
      // Cycle-end hold only counts while aux regulates
      main_pwm_off_o       <= fault_shdn_i &&
                              (shdn_r == plr_pkg::SHDN_OFF ||
                               !(aux_regulating_i && uv_limit_r[plr_pkg::EOC_SHDN_BIT]));
    end
  end

  // ==========================================================
  // Load line droop
  plr_droop u_droop (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .enable_i  (droop_ctrl_r[plr_pkg::DROOP_EN_BIT]),
    .sel_i     (droop_ctrl_r[plr_pkg::DROOP_SEL_MSB:0]),
    .load_i    (load_i),
    .droop_o   (droop_o)
  );
endmodule : plr_top
`default_nettype wire

// *** dv/plr_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====
// Port checker
module plr_monitor (
  input wire logic        sys_clk_i,  // Clock
  input wire logic        rst_b_i,    // Reset
  input wire logic [7:0]  reg_addr_i, // Address
  input wire logic        reg_rd_i,   // Read
  input wire logic [7:0]  reg_rdata_o,  // Read data
  input wire logic [10:0] local_sense_voltage_i, // Sense
  input wire logic [7:0]  line_imp_i, // Impedance
  input wire logic        fault_shdn_i, // Fault
  input wire logic        aux_regulating_i, // Aux regulates
  input wire logic [10:0] uv_threshold_o, // Threshold
  input wire logic        undervoltage_protection_o, // Undervoltage
  input wire logic        line_imp_flag_o, // Flag
  input wire logic        aux_pwm_output_off_o, // Aux off
  input wire logic        main_pwm_off_o, // Main off
  input wire logic [10:0] droop_o     // Droop
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Status read request
  sequence status_rd;
    reg_rd_i && reg_addr_i == plr_pkg::STATUS_OFF;
  endsequence
  aux_stop_a: assert property (fault_shdn_i |=> aux_pwm_output_off_o) else $error("aux on");
  aux_free_a: assert property (!fault_shdn_i |=> !aux_pwm_output_off_o) else $error("aux off");
  main_now_a: assert property (fault_shdn_i && !aux_regulating_i |=> main_pwm_off_o)
    else $error("main late");
  main_cause_a: assert property ($rose(main_pwm_off_o) |-> $past(fault_shdn_i))
    else $error("main cause");
  uv_cmp_a: assert property (undervoltage_protection_o ==
    ($past(local_sense_voltage_i) < uv_threshold_o)) else $error("uv compare");
  thr_max_a: assert property (uv_threshold_o <= 11'h601) else $error("thr range");
  flag_zero_a: assert property ($past(line_imp_i) == 8'h00 |-> !line_imp_flag_o)
    else $error("flag set");
  droop_max_a: assert property (droop_o <= 11'h405) else $error("droop range");
  status_rd_a: assert property (status_rd |=> reg_rdata_o ==
    {5'h00, $past(line_imp_flag_o), 2'h0}) else $error("status read");
endmodule : plr_monitor
bind plr_top plr_monitor plr_monitor_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
  .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .local_sense_voltage_i(local_sense_voltage_i), .line_imp_i(line_imp_i),
  .fault_shdn_i(fault_shdn_i), .aux_regulating_i(aux_regulating_i),
  .uv_threshold_o(uv_threshold_o), .undervoltage_protection_o(undervoltage_protection_o),
  .line_imp_flag_o(line_imp_flag_o), .aux_pwm_output_off_o(aux_pwm_output_off_o),
  .main_pwm_off_o(main_pwm_off_o), .droop_o(droop_o));
`default_nettype wire

// *** dv/plr_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module plr_top_tb;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, fault = 1'b0, auxr = 1'b0, ce = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, limp = 8'h00, rdata;
  logic [10:0] sense = 11'h000, thr, droop;
  logic [11:0] load = 12'h000;
  logic uv, lflag, aoff, moff;
  int n_errors = 0, n_checks = 0;
  int uvs[3] = '{0, 66, 127};
  logic [10:0] imp[8] = '{plr_pkg::IMP_CODE0, plr_pkg::IMP_CODE1, plr_pkg::IMP_CODE2,
    plr_pkg::IMP_CODE3, plr_pkg::IMP_CODE4, plr_pkg::IMP_CODE5, plr_pkg::IMP_CODE6,
    plr_pkg::IMP_CODE7};
  // ====
  // Clock and design
  always #5 clk = ~clk;
  plr_top plr_top_i (.sys_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .local_sense_voltage_i(sense),
    .line_imp_i(limp), .load_i(load), .fault_shdn_i(fault), .aux_regulating_i(auxr),
    .cycle_end_i(ce), .uv_threshold_o(thr), .undervoltage_protection_o(uv),
    .line_imp_flag_o(lflag), .aux_pwm_output_off_o(aoff), .main_pwm_off_o(moff), .droop_o(droop));
  // Compare and count
  task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  // Register bus cycles
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(1);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    chk("rdata", {3'h0, exp}, {3'h0, rdata});
    step(1);
  endtask : rd_reg
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  // Watchdog
  initial begin
    #20000;
    n_errors++;
    test_done();
  end
  // Main sequence
  initial begin
    step(5);
    rst_b = 1'b1;
    for (int a = 8'h34; a < 8'h37; a++) rd_reg(8'(a), 8'h00);
    rd_reg(8'h40, 8'h00);
    foreach (uvs[i]) begin
      wr_reg(8'h34, 8'(uvs[i]));
      step(1);
      chk("thr", 11'((uvs[i] * 1550) >> 7), thr);
    end
    wr_reg(8'h34, 8'hc2);
    sense = 11'd798;
    step(2);
    chk("uv", 11'h001, {10'h0, uv});
    rd_reg(8'h34, 8'hc2);
    wr_reg(8'h35, 8'h10);
    limp = 8'h10;
    step(2);
    chk("lflag", 11'h000, {10'h0, lflag});
    limp = 8'h11;
    step(1);
    chk("lflag", 11'h001, {10'h0, lflag});
    wr_reg(8'h02, 8'hff);
    rd_reg(8'h02, 8'h04);
    load = 12'hfff;
    wr_reg(8'h36, 8'hf0);
    step(1);
    chk("droop", 11'h000, droop);
    for (int c = 0; c < 8; c++) begin
      wr_reg(8'h36, 8'h08 | 8'(c));
      step(1);
      chk("droop", 11'((4095 * imp[c]) >> 12), droop);
    end
    wr_reg(8'h36, 8'h08);
    load = 12'h800;
    step(2);
    chk("droop", 11'((2048 * imp[0]) >> 12), droop);
    fault = 1'b1;
    step(1);
    chk("moff", 11'h001, {10'h0, moff});
    fault = 1'b0;
    step(3);
    auxr = 1'b1;
    fault = 1'b1;
    step(2);
    chk("aoff", 11'h001, {10'h0, aoff});
    chk("moff", 11'h000, {10'h0, moff});
    ce = 1'b1;
    step(1);
    ce = 1'b0;
    chk("moff", 11'h000, {10'h0, moff});
    step(1);
    chk("moff", 11'h001, {10'h0, moff});
    fault = 1'b0;
    step(3);
    wr_reg(8'h34, 8'h42);
    fault = 1'b1;
    step(1);
    chk("moff", 11'h001, {10'h0, moff});
    test_done();
  end
endmodule : plr_top_tb
`default_nettype wire
